//--- hdl/pvsc_regs.sv
// Vendor status and control register bank behind an APB slave
//
// Implementation choice: register access over APB.
module pvsc_regs
	import pvsc_pkg::*;
(
	input  wire logic                        i_clock,
	input  wire logic                        i_rst_n,
	input  wire pvsc_pkg::pvsc_apb_req_type  i_apb,
	output      pvsc_pkg::pvsc_apb_rsp_type  o_apb,
	input  wire pvsc_pkg::pvsc_link_in_type  i_link,
	output      pvsc_pkg::pvsc_ctrl_out_type o_ctrl,
	output      logic                        o_irq,
	output      logic                        o_int_pin
);
	import pvsc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a[1:0] == 2'h0) && (a[7] == 1'b0) &&
			(a[6:2] == IDX_RXERR || a[6:2] == IDX_INT ||
			 a[6:2] == IDX_CTL1 || a[6:2] == IDX_CTL2);
	endfunction : addr_hit

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] val, input logic [15:0] msk);
		merge = (old & ~msk) | (val & msk);
	endfunction : merge

	pvsc_state_type s_q;
	pvsc_state_type s_d;

	logic        acc;
	logic        done;
	logic        hit;
	logic [4:0]  idx;
	logic [15:0] wmask;
	logic [15:0] wdat;
	logic        wr;
	logic        rd;
	logic [7:0]  ev;
	logic [15:0] img_ctl1;
	logic [15:0] img_ctl2;
	logic [15:0] rd_val;

	assign acc   = i_apb.psel & i_apb.penable;
	assign done  = acc && (s_q.bus == BUS_DONE);
	assign hit   = addr_hit(i_apb.paddr);
	assign idx   = i_apb.paddr[6:2];
	assign wmask = {{8{i_apb.pstrb[1]}}, {8{i_apb.pstrb[0]}}};
	assign wdat  = i_apb.pwdata[15:0];
	assign wr    = done & i_apb.pwrite & hit;
	assign rd    = done & ~i_apb.pwrite & hit;

	// Page arrival joins the other events at its flag position
	assign ev = i_link.events |
		(8'h01 << EV_PAGE) & {8{i_link.page_received}}; // [R19]

	// ----------------------------------------
	// Register images as software sees them
	// ----------------------------------------
	assign img_ctl1 = {s_q.led_mode,
		i_link.polarity_rev,            // [R07]
		1'b0,
		s_q.ctrl.pair_swap,
		3'h0,
		s_q.ctrl.remote_loopback,       // [R08]
		7'h00};
	assign img_ctl2 = {s_q.ctrl.alt_crossover_algorithm,
		s_q.mdix_sel,
		s_q.ctrl.auto_crossover_off,
		i_link.energy,                  // [R12]
		s_q.ctrl.force_link,
		s_q.power_save,
		s_q.int_level,
		s_q.ctrl.jabber_enable,
		i_link.autoneg_done,            // [R16]
		i_link.flow_capable,            // [R17]
		i_link.isolate,                 // [R18]
		5'h00};

	always_comb
	begin
		unique case (idx)
			IDX_RXERR: rd_val = s_q.count;
			IDX_INT:   rd_val = {s_q.int_en, s_q.int_flag};
			IDX_CTL1:  rd_val = img_ctl1;
			IDX_CTL2:  rd_val = img_ctl2;
			default:   rd_val = 16'h0000;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic [15:0] t;
		logic [15:0] sub;
		logic [7:0]  clr;
		t   = 16'h0000;
		sub = 16'h0000;
		clr = 8'h00;
		s_d = s_q;

		// Answer one cycle into the access phase, data held meanwhile
		unique case (s_q.bus)
			BUS_IDLE:
				if (acc)
				begin
					s_d.bus         = BUS_DONE;
					s_d.rsp.pready  = 1'b1;
					s_d.rsp.pslverr = ~hit;
					s_d.rsp.prdata  = {16'h0000, hit ? rd_val : 16'h0000};
				end
			BUS_DONE:
			begin
				s_d.bus = BUS_IDLE;
				s_d.rsp = '0;
			end
		endcase

		// Reading removes only what was reported, so later counts survive
		if (rd && idx == IDX_RXERR)
			sub = s_q.rsp.prdata[15:0]; // [R01]
		t = s_q.count - sub;
		if (i_link.symbol_error_frame && t != CNT_MAX)
			t = t + 16'h0001;
		s_d.count = t; // [R01]

		// Flags: cleared by read or by write-one, a new event wins
		if (rd && idx == IDX_INT)
			clr = s_q.rsp.prdata[7:0]; // [R03]
		if (wr && idx == IDX_INT)
			clr = clr | (wdat[7:0] & wmask[7:0]);
		s_d.int_flag = (s_q.int_flag & ~clr) | ev; // [R03]

		if (wr && idx == IDX_INT)
		begin
			t = merge({s_q.int_en, 8'h00}, wdat, wmask);
			s_d.int_en = t[15:8]; // [R02]
		end

		if (wr && idx == IDX_CTL1)
		begin
			t = merge(img_ctl1, wdat, wmask);
			s_d.led_mode             = t[15:14]; // [R06]
			s_d.ctrl.remote_loopback = t[7];     // [R08]
		end

		if (wr && idx == IDX_CTL2)
		begin
			t = merge(img_ctl2, wdat, wmask);
			s_d.ctrl.alt_crossover_algorithm = t[15]; // [R09]
			s_d.mdix_sel                     = t[14]; // [R10]
			s_d.ctrl.auto_crossover_off      = t[13]; // [R11]
			s_d.ctrl.force_link              = t[11]; // [R13]
			s_d.power_save                   = t[10]; // [R14]
			s_d.int_level                    = t[9];  // [R05]
			s_d.ctrl.jabber_enable           = t[8];  // [R15]
		end

		// Manual mapping only counts while auto crossover is off
		s_d.ctrl.pair_swap = s_q.ctrl.auto_crossover_off ?
			s_q.mdix_sel : i_link.auto_mdix_state; // [R10] [R11]

		// Reserved codes fall back to the default pairing
		if (s_q.led_mode == LED_ACTLNK)
		begin
			s_d.ctrl.indicator_one  = i_link.activity; // [R06]
			s_d.ctrl.indicator_zero = i_link.link_up;
		end
		else
		begin
			s_d.ctrl.indicator_one  = i_link.speed100; // [R06]
			s_d.ctrl.indicator_zero = i_link.link_up & ~i_link.activity;
		end

		// Clock stays off after unplug until energy and link both return
		if (!s_q.power_save)
			s_d.ctrl.receive_clock_output_en = 1'b1;
		else if (!i_link.energy)
			s_d.ctrl.receive_clock_output_en = 1'b0; // [R14]
		else if (i_link.link_up)
			s_d.ctrl.receive_clock_output_en = 1'b1; // [R14]

		s_d.irq     = |(s_d.int_flag & s_d.int_en); // [R04]
		s_d.int_pin = s_d.irq ~^ s_d.int_level;     // [R05]
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_q <= STATE_RST;
		else
			s_q <= s_d;
	end

	assign o_apb     = s_q.rsp;
	assign o_ctrl    = s_q.ctrl;
	assign o_irq     = s_q.irq;
	assign o_int_pin = s_q.int_pin;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_count_read;
		rd && idx == IDX_RXERR && !i_link.symbol_error_frame;
	endsequence

	a_count_read_clear: assert property ( // [R01]
		s_count_read |=> s_q.count ==
			$past(s_q.count) - $past(s_q.rsp.prdata[15:0]))
		else $error("count not reduced by reported value");

	a_enable_write: assert property ( // [R02]
		wr && idx == IDX_INT && i_apb.pstrb[1] |=>
			s_q.int_en == $past(wdat[15:8]))
		else $error("interrupt enables not written");

	a_flag_sticky: assert property ( // [R03]
		ev[0] ##1 !(done && idx == IDX_INT) [*2] |->
			s_q.int_flag[0])
		else $error("event flag lost");

	a_irq_level: assert property ( // [R04]
		|(s_q.int_flag & s_q.int_en) == o_irq)
		else $error("interrupt not tied to enabled flags");

	a_pin_polarity: assert property ( // [R05]
		o_int_pin == (o_irq ~^ s_q.int_level))
		else $error("interrupt pin polarity wrong");

	a_led_actlink: assert property ( // [R06]
		s_q.led_mode == LED_ACTLNK |=>
			o_ctrl.indicator_one == $past(i_link.activity))
		else $error("indicator one not showing activity");

	a_swap_manual: assert property ( // [R10]
		s_q.ctrl.auto_crossover_off |=>
			o_ctrl.pair_swap == $past(s_q.mdix_sel))
		else $error("manual pair mapping ignored");

	a_rxclk_gate: assert property ( // [R14]
		s_q.power_save && !i_link.energy |=>
			!o_ctrl.receive_clock_output_en)
		else $error("receive clock not stopped");

	a_ready_once: assert property (
		acc && s_q.bus == BUS_IDLE |=> o_apb.pready ##1 !o_apb.pready)
		else $error("bus answer not one cycle");

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	a_answer_quiet: assert property (
		!acc && s_q.bus == BUS_IDLE |=> !o_apb.pready)
		else $error("bus answer without a request");

	// Refused accesses still get an answer, so the master never hangs
	a_unmapped_error: assert property (
		acc && s_q.bus == BUS_IDLE && !hit |=>
			o_apb.pslverr && o_apb.prdata == 32'h00000000)
		else $error("unmapped access not refused");

	a_read_polarity: assert property ( // [R07]
		acc && s_q.bus == BUS_IDLE && hit && idx == IDX_CTL1 |=>
			o_apb.prdata[13] == $past(i_link.polarity_rev))
		else $error("reversed polarity not reported");

	a_read_status: assert property ( // [R12] [R16] [R17] [R18]
		acc && s_q.bus == BUS_IDLE && hit && idx == IDX_CTL2 |=>
			o_apb.prdata[12] == $past(i_link.energy) &&
			o_apb.prdata[7:5] == $past({i_link.autoneg_done,
				i_link.flow_capable, i_link.isolate}))
		else $error("status bits not reported");

	// ----------------------------------------
	// Counter, event flags and enables
	// ----------------------------------------
	sequence s_count_event;
		!rd && i_link.symbol_error_frame && s_q.count != CNT_MAX;
	endsequence

	sequence s_count_quiet;
		!rd && !i_link.symbol_error_frame;
	endsequence

	a_count_step: assert property ( // [R01]
		s_count_event |=> s_q.count == $past(s_q.count) + 16'h0001)
		else $error("symbol error frame not counted");

	a_count_hold: assert property ( // [R01]
		s_count_quiet |=> $stable(s_q.count))
		else $error("count changed without cause");

	a_flag_set: assert property ( // [R03]
		ev != 8'h00 |=> (s_q.int_flag & $past(ev)) == $past(ev))
		else $error("event did not set its flag");

	a_flag_read_clear: assert property ( // [R03]
		rd && idx == IDX_INT && ev == 8'h00 |=>
			(s_q.int_flag & $past(s_q.rsp.prdata[7:0])) == 8'h00)
		else $error("reported flag not cleared by read");

	a_flag_spurious: assert property ( // [R03]
		ev == 8'h00 |=> (s_q.int_flag & ~$past(s_q.int_flag)) == 8'h00)
		else $error("flag set without an event");

	a_page_flag: assert property ( // [R19]
		i_link.page_received |=> s_q.int_flag[EV_PAGE])
		else $error("page arrival not flagged");

	a_enable_hold: assert property ( // [R02]
		!(wr && idx == IDX_INT) |=> $stable(s_q.int_en))
		else $error("interrupt enables changed unasked");

	// Only a completed access may remove a flag
	for (genvar g = 0; g < 8; g++)
	begin : g_flag
		a_flag_hold: assert property ( // [R03]
			s_q.int_flag[g] && !done |=> s_q.int_flag[g])
			else $error("event flag dropped without access");
	end

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	sequence s_ctl1_full_write;
		wr && idx == IDX_CTL1 && i_apb.pstrb[1:0] == 2'h3;
	endsequence

	sequence s_ctl2_high_write;
		wr && idx == IDX_CTL2 && i_apb.pstrb[1];
	endsequence

	a_ctl1_write: assert property ( // [R06] [R08]
		s_ctl1_full_write |=> s_q.led_mode == $past(wdat[15:14]) &&
			o_ctrl.remote_loopback == $past(wdat[7]))
		else $error("control one fields not written");

	a_ctl2_write: assert property ( // [R09] [R11] [R13] [R15]
		s_ctl2_high_write |=>
			o_ctrl.alt_crossover_algorithm == $past(wdat[15]) &&
			o_ctrl.auto_crossover_off == $past(wdat[13]) &&
			o_ctrl.force_link == $past(wdat[11]) &&
			o_ctrl.jabber_enable == $past(wdat[8]))
		else $error("control two fields not written");

	a_ctl2_modes: assert property ( // [R05] [R10] [R14]
		s_ctl2_high_write |=> s_q.mdix_sel == $past(wdat[14]) &&
			s_q.power_save == $past(wdat[10]) &&
			s_q.int_level == $past(wdat[9]))
		else $error("control two modes not written");

	a_swap_auto: assert property ( // [R11]
		!s_q.ctrl.auto_crossover_off |=>
			o_ctrl.pair_swap == $past(i_link.auto_mdix_state))
		else $error("automatic pair mapping ignored");

	a_led_default: assert property ( // [R06]
		s_q.led_mode != LED_ACTLNK |=>
			o_ctrl.indicator_one == $past(i_link.speed100))
		else $error("indicator one not showing speed");

	a_led_link: assert property ( // [R06]
		s_q.led_mode == LED_ACTLNK |=>
			o_ctrl.indicator_zero == $past(i_link.link_up))
		else $error("indicator zero not showing link");

	// Without power saving the receive clock must never be held off
	a_rxclk_free: assert property ( // [R14]
		!s_q.power_save |=> o_ctrl.receive_clock_output_en)
		else $error("receive clock held without power saving");

	a_rxclk_wait: assert property ( // [R14]
		s_q.power_save && !i_link.link_up &&
			!o_ctrl.receive_clock_output_en |=>
			!o_ctrl.receive_clock_output_en)
		else $error("receive clock restarted without link");

	a_rxclk_resume: assert property ( // [R14]
		s_q.power_save && i_link.energy && i_link.link_up |=>
			o_ctrl.receive_clock_output_en)
		else $error("receive clock not restarted");
endmodule : pvsc_regs

//--- inc/pvsc_pkg.sv
// Package: constants and types of the transceiver vendor register bank
// What this block does
// [R01] 16-bit symbol-error frame count, resets to zero, cleared by reading it
// [R02] Eight read/write interrupt enables in bits 15..8, reset to zero
// [R03] Eight sticky event flags in bits 7..0, cleared after being read
// [R04] Interrupt active while any flag is set with its enable set
// [R05] Control two bit 9 picks interrupt pin polarity, 1 high, reset 0
// [R06] Indicator mode bits 15..14: 00 speed and link/activity, 01 activity/link
// [R07] Control one bit 13 reports reversed receive pair polarity
// [R08] Control one bit 7 enables remote analog loopback, reset 0
// [R09] Control two bit 15 picks crossover algorithm, resets to 1 (alternate)
// [R10] With auto crossover off, bit 14 fixes pair mapping, 1 swaps
// [R11] Control two bit 13 disables automatic crossover when 1, reset 0
// [R12] Control two bit 12 reports energy on the receive pair
// [R13] Bit 11 forces link pass, bypassing link control logic
// [R14] Power saving stops receive clock while unplugged, restarts on link
// [R15] Control two bit 8 enables the jabber counter, resets to 1
// [R16] Control two bit 7 reports negotiation complete, reset 0
// [R17] Control two bit 6 reports flow control capability, reset 0
// [R18] Control two bit 5 reports isolate mode, reset 0
// [R19] A newly received page raises the page-received event flag
package pvsc_pkg;
	// ----------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------
	localparam logic [4:0]  IDX_RXERR  = 5'h15;
	localparam logic [4:0]  IDX_INT    = 5'h1b;
	localparam logic [4:0]  IDX_CTL1   = 5'h1e;
	localparam logic [4:0]  IDX_CTL2   = 5'h1f;
	localparam logic [15:0] CNT_MAX    = 16'hffff;
	localparam int          EV_PAGE    = 5;
	localparam logic [1:0]  LED_ACTLNK = 2'h1;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} pvsc_apb_req_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pvsc_apb_rsp_type;
	typedef struct packed {
		logic       link_up;
		logic       activity;
		logic       speed100;
		logic       energy;
		logic       polarity_rev;
		logic       auto_mdix_state;
		logic       autoneg_done;
		logic       flow_capable;
		logic       isolate;
		logic       symbol_error_frame;
		logic       page_received;
		logic [7:0] events;
	} pvsc_link_in_type;
	typedef struct packed {
		logic indicator_one;
		logic indicator_zero;
		logic remote_loopback;
		logic alt_crossover_algorithm;
		logic auto_crossover_off;
		logic pair_swap;
		logic force_link;
		logic jabber_enable;
		logic receive_clock_output_en;
	} pvsc_ctrl_out_type;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DONE = 2'b10
	} pvsc_bus_state_type;
	typedef struct packed {
		pvsc_bus_state_type bus;
		pvsc_apb_rsp_type   rsp;
		logic [15:0]        count;
		logic [7:0]         int_en;
		logic [7:0]         int_flag;
		logic [1:0]         led_mode;
		logic               mdix_sel;
		logic               power_save;
		logic               int_level;
		logic               irq;
		logic               int_pin;
		pvsc_ctrl_out_type  ctrl;
	} pvsc_state_type;
	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam pvsc_ctrl_out_type CTRL_RST = '{
		alt_crossover_algorithm: 1'b1,
		jabber_enable: 1'b1,
		receive_clock_output_en: 1'b1,
		default: 1'b0};
	localparam pvsc_state_type STATE_RST = '{
		bus: BUS_IDLE,
		rsp: '0,
		count: 16'h0000,
		int_en: 8'h00,
		int_flag: 8'h00,
		led_mode: 2'h0,
		int_pin: 1'b1,
		ctrl: CTRL_RST,
		default: '0};
endpackage : pvsc_pkg

//--- tb/pvsc_mgmt.sv
// Management controller model: APB master in front of the register bank
module pvsc_mgmt
	import pvsc_pkg::*;
(
	input  wire logic                       i_clock,
	output      pvsc_pkg::pvsc_apb_req_type o_apb,
	input  wire pvsc_pkg::pvsc_apb_rsp_type i_apb
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_apb = '0;

	// ----------------------------------------
	// One transfer, entered right after a rising edge
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output logic err);
		// One edge passes first, so a release and a setup never share a step
		@(posedge i_clock);
		o_apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w,
			pwdata: {16'h0000, wd}, pstrb: w ? 4'h3 : 4'h0};
		@(posedge i_clock);
		o_apb.penable <= 1'b1;
		// No latency assumed; the bench timeout cuts a hang
		do
			@(posedge i_clock);
		while (i_apb.pready !== 1'b1);
		rd = i_apb.prdata[15:0];
		err = i_apb.pslverr;
		// Released lines show no stale value
		o_apb <= '{paddr: ~a, pwdata: ~{16'h0000, wd}, default: '0};
	endtask : xfer
endmodule : pvsc_mgmt

//--- tb/test_phy_vendor_status_control_regs.sv
// Self-checking bench of the vendor register bank
module test_phy_vendor_status_control_regs;
	import pvsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic              i_clock = 1'b0;
	logic              i_rst_n = 1'b0;
	pvsc_apb_req_type  apb_req;
	pvsc_apb_rsp_type  apb_rsp;
	pvsc_link_in_type  lk = '0;
	pvsc_ctrl_out_type ctl;
	logic              irq;
	logic              int_pin;
	logic [15:0]       d;
	logic              f;
	int                err_total = 0;
	int                checks = 0;
	int                cycles = 0;

	always #10 i_clock = ~i_clock;

	pvsc_regs DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_apb(apb_req),
		.o_apb(apb_rsp), .i_link(lk), .o_ctrl(ctl), .o_irq(irq),
		.o_int_pin(int_pin));
	pvsc_mgmt u_mgmt (.i_clock(i_clock), .o_apb(apb_req), .i_apb(apb_rsp));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask : cyc

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		u_mgmt.xfer(1'b0, a, 16'h0000, d, f);
		chk(d, e);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		u_mgmt.xfer(1'b1, a, v, d, f);
	endtask : wr

	// Hang guard: far above the fewer than two hundred cycles the tests need
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_total++;
			conclude();
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		cyc(4);
		i_rst_n <= 1'b1;
		cyc(1);
		chk(ctl, CTRL_RST);
		chk(int_pin, 1'b1);
		rd(8'h54, 16'h0000);
		rd(8'h6c, 16'h0000);
		rd(8'h78, 16'h0000);
		rd(8'h7c, 16'h8100);
		u_mgmt.xfer(1'b0, 8'h40, 16'h0000, d, f);
		chk({15'h0000, f}, 16'h0001);
		chk(d, 16'h0000);
		lk.symbol_error_frame <= 1'b1;
		cyc(3);
		lk.symbol_error_frame <= 1'b0;
		rd(8'h54, 16'h0003);
		rd(8'h54, 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			lk.events[i] <= 1'b1;
			cyc(1);
			lk.events[i] <= 1'b0;
			rd(8'h6c, 16'h0001 << i);
			rd(8'h6c, 16'h0000);
		end
		lk.page_received <= 1'b1;
		cyc(1);
		lk.page_received <= 1'b0;
		rd(8'h6c, 16'h0020);
		// Enable link down only; remote fault stays masked
		wr(8'h6c, 16'h0400);
		lk.events[1] <= 1'b1;
		cyc(1);
		lk.events[1] <= 1'b0;
		cyc(2);
		chk({irq, int_pin}, 2'b01);
		lk.events[2] <= 1'b1;
		cyc(1);
		lk.events[2] <= 1'b0;
		cyc(2);
		chk({irq, int_pin}, 2'b10);
		wr(8'h7c, 16'h8300);
		cyc(2);
		chk(int_pin, 1'b1);
		rd(8'h6c, 16'h0406);
		cyc(2);
		chk({irq, int_pin}, 2'b00);
		wr(8'h78, 16'h4080);
		lk.polarity_rev <= 1'b1;
		cyc(2);
		chk(ctl.remote_loopback, 1'b1);
		rd(8'h78, 16'h6080);
		{lk.link_up, lk.activity, lk.speed100} <= 3'b110;
		cyc(3);
		chk({ctl.indicator_one, ctl.indicator_zero}, 2'b11);
		wr(8'h78, 16'h0000);
		cyc(3);
		chk({ctl.indicator_one, ctl.indicator_zero}, 2'b00);
		{lk.energy, lk.autoneg_done, lk.flow_capable, lk.isolate} <= 4'hf;
		wr(8'h7c, 16'h6800);
		cyc(2);
		chk({ctl.alt_crossover_algorithm, ctl.pair_swap}, 2'b01);
		chk({ctl.auto_crossover_off, ctl.force_link}, 2'b11);
		chk(ctl.jabber_enable, 1'b0);
		rd(8'h7c, 16'h78e0);
		rd(8'h78, 16'h2800);
		{lk.energy, lk.link_up} <= 2'b00;
		wr(8'h7c, 16'h0400);
		cyc(2);
		chk(ctl.receive_clock_output_en, 1'b0);
		lk.energy <= 1'b1;
		cyc(3);
		chk(ctl.receive_clock_output_en, 1'b0);
		lk.link_up <= 1'b1;
		cyc(3);
		chk(ctl.receive_clock_output_en, 1'b1);
		lk.auto_mdix_state <= 1'b1;
		cyc(2);
		chk(ctl.pair_swap, 1'b1);
		conclude();
	end
endmodule : test_phy_vendor_status_control_regs
